// File: core/atr_aux_limit_regs.sv
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
`include "atr_regs.svh"

// What this block does
// - limits are offset-binary codes, 0 V to 5 V
// - limit bits 1:0 reserved, read as zero
// - aux3 low limit held in bits 15:2
// - aux3 high limit held in bits 15:2
// - aux4 low limit held and applied
// - aux4 high limit held and applied
// - aux5 low limit held and applied
// - aux5 high limit held and applied
// - aux6 low limit held and applied
// - aux6 high limit held and applied
// - aux7 low limit held and applied
// - aux7 high limit held and applied
// - 64-bit lot identifier readable by host
// - 16-bit serial identifier readable by host

module atr_aux_limit_regs #(
    parameter logic [63:0] LOT_ID = 64'h0123_4567_89AB_CDEF, // arbitrary value
    parameter logic [15:0] SER_ID = 16'h2B4D                 // arbitrary value
) (
    // clock and reset
    input  wire logic               ref_clk,
    input  wire logic               sys_rst,
    // avalon-mm slave, byte addressed
    input  wire logic [9:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [3:0]         avs_byteenable,
    input  wire logic [31:0]        avs_writedata,
    output logic [31:0]             avs_readdata,
    output logic                    avs_waitrequest,
    // auxiliary sample stream
    input  wire logic               sample_valid,
    input  wire atr_pkg::atr_chan_t sample_channel,
    input  wire logic [15:0]        sample_code,
    // sticky fault flags, bit 0 is channel 3
    output atr_pkg::atr_flags_t     aux_low_fault,
    output atr_pkg::atr_flags_t     aux_high_fault,
    output logic                    aux_fault_any
);
    import atr_pkg::*;

    // limit slot decode: returns hit flag and slot number
    function automatic logic [4:0] lim_slot(input logic [9:0] addr);
        logic [4:0] res;
        res = 5'h00;
        if (addr[1:0] == 2'h0) begin
            unique case (addr[9:2])
                `ATR_IDX_AUX3_LO: res = 5'h10;
                `ATR_IDX_AUX3_HI: res = 5'h11;
                `ATR_IDX_AUX4_LO: res = 5'h12;
                `ATR_IDX_AUX4_HI: res = 5'h13;
                `ATR_IDX_AUX5_LO: res = 5'h14;
                `ATR_IDX_AUX5_HI: res = 5'h15;
                `ATR_IDX_AUX6_LO: res = 5'h16;
                `ATR_IDX_AUX6_HI: res = 5'h17;
                `ATR_IDX_AUX7_LO: res = 5'h18;
                `ATR_IDX_AUX7_HI: res = 5'h19;
                default:          res = 5'h00;
            endcase
        end
        return res;
    endfunction : lim_slot

    // exact word match on a register index
    function automatic logic idx_hit(input logic [9:0] addr, input logic [7:0] idx);
        return (addr == {idx, 2'h0});
    endfunction : idx_hit

    atr_state_s r_q;      // registered state
    atr_state_s r_d;      // next state

    logic       req;      // read or write pending
    logic [4:0] slot_dec; // decoded limit slot
    logic       lim_hit;  // address names a limit
    logic [3:0] slot;     // limit slot number
    logic [31:0] rd_mux;  // read data selected by address
    logic       flt_wr;   // accepted write to the fault register
    atr_flags_t below;    // per-channel under-limit compare
    atr_flags_t above;    // per-channel over-limit compare
    atr_flags_t ch_sel;   // channel of the current sample
    atr_lim_t   lim_new;  // limit after byte-lane merge

    assign req      = avs_read | avs_write;
    assign slot_dec = lim_slot(avs_address);
    assign lim_hit  = slot_dec[4];
    assign slot     = slot_dec[3:0];

    // one comparator per channel, all fed by the shared sample code
    genvar gc;
    generate
        for (gc = 0; gc < ATR_NCH; gc++) begin : g_cmp
            atr_aux_cmp u_cmp (
                .code     (sample_code[`ATR_LIM_MSB:`ATR_LIM_LSB]),
                .low_lim  (r_q.lim[2*gc]),
                .high_lim (r_q.lim[2*gc+1]),
                .below    (below[gc]),
                .above    (above[gc])
            );
            // sample belongs to this channel
            assign ch_sel[gc] = sample_valid &&
                (sample_channel == `ATR_FIRST_CH + 3'(gc));
        end
    endgenerate

    // read multiplexer; unmapped words read as zero
    always_comb begin
        rd_mux = `ATR_RDATA_RST;
        if (lim_hit) begin
            // reserved low bits always return zero
            rd_mux[15:0] = {r_q.lim[slot], `ATR_RSVD_ZERO};
        end else if (idx_hit(avs_address, `ATR_IDX_LOT_HI)) begin
            rd_mux = LOT_ID[63:32];
        end else if (idx_hit(avs_address, `ATR_IDX_LOT_LO)) begin
            rd_mux = LOT_ID[31:0];
        end else if (idx_hit(avs_address, `ATR_IDX_SERIAL)) begin
            rd_mux[15:0] = SER_ID;
        end else if (idx_hit(avs_address, `ATR_IDX_FAULT)) begin
            rd_mux[`ATR_FLT_LO_LSB +: ATR_NCH] = r_q.lo_flt;
            rd_mux[`ATR_FLT_HI_LSB +: ATR_NCH] = r_q.hi_flt;
        end
    end

    // byte-lane merge of a limit write; bits 1:0 are dropped
    always_comb begin
        lim_new = r_q.lim[slot];
        if (avs_byteenable[0]) begin
            lim_new[5:0] = avs_writedata[7:2];
        end
        if (avs_byteenable[1]) begin
            lim_new[13:6] = avs_writedata[15:8];
        end
    end

    // write to the fault register in its accepting cycle
    assign flt_wr = (r_q.st == ATR_ACK) && avs_write &&
        idx_hit(avs_address, `ATR_IDX_FAULT);

    // next-state logic for bus handshake, limits and faults
    always_comb begin
        r_d = r_q;
        unique case (r_q.st)
            ATR_IDLE: begin
                // take the request; answer in the next cycle
                if (req) begin
                    r_d.st     = ATR_ACK;
                    r_d.wait_q = 1'b0;
                    r_d.rdata  = avs_read ? rd_mux : `ATR_RDATA_RST;
                end
            end
            ATR_ACK: begin
                // master samples waitrequest low at this edge
                r_d.st     = ATR_IDLE;
                r_d.wait_q = 1'b1;
                r_d.rdata  = `ATR_RDATA_RST;
                // limit writes land at the same edge; fault register clears land there too, below
                if (avs_write && lim_hit) begin
                    r_d.lim[slot] = lim_new;
                end
            end
        endcase
        // write-one-to-clear, applied before the new events
        if (flt_wr && avs_byteenable[0]) begin
            r_d.lo_flt = r_q.lo_flt & ~avs_writedata[`ATR_FLT_LO_LSB +: ATR_NCH];
        end
        if (flt_wr && avs_byteenable[1]) begin
            r_d.hi_flt = r_q.hi_flt & ~avs_writedata[`ATR_FLT_HI_LSB +: ATR_NCH];
        end
        // new events win over a clear in the same cycle
        r_d.lo_flt  = r_d.lo_flt | (ch_sel & below);
        r_d.hi_flt  = r_d.hi_flt | (ch_sel & above);
        r_d.any_flt = (|r_d.lo_flt) | (|r_d.hi_flt);
    end

    // state register; limits reset to the widest window
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            r_q.st      <= ATR_IDLE;
            r_q.wait_q  <= 1'b1;
            r_q.rdata   <= `ATR_RDATA_RST;
            for (int i = 0; i < ATR_NCH; i++) begin
                r_q.lim[2*i]   <= `ATR_LOW_RST;
                r_q.lim[2*i+1] <= `ATR_HIGH_RST;
            end
            r_q.lo_flt  <= `ATR_FLT_RST;
            r_q.hi_flt  <= `ATR_FLT_RST;
            r_q.any_flt <= 1'b0;
        end else begin
            r_q <= r_d;
        end
    end

    // outputs straight from the state flops
    assign avs_readdata    = r_q.rdata;
    assign avs_waitrequest = r_q.wait_q;
    assign aux_low_fault   = r_q.lo_flt;
    assign aux_high_fault  = r_q.hi_flt;
    assign aux_fault_any   = r_q.any_flt;

    // checks on the bank's own behaviour
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    // a request is taken in idle
    sequence s_take;
        r_q.st == ATR_IDLE && req;
    endsequence

    // a read of one register index is taken
    sequence s_rd(logic [7:0] idx);
        r_q.st == ATR_IDLE && avs_read && idx_hit(avs_address, idx);
    endsequence

    // a full-word write of one index is accepted
    sequence s_wr(logic [7:0] idx);
        r_q.st == ATR_ACK && avs_write && avs_byteenable == 4'hF &&
            idx_hit(avs_address, idx);
    endsequence

    // one wait cycle, then exactly one answer cycle
    a_wait_one_cycle:
    assert property (s_take |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("waitrequest not low for exactly one cycle");

    a_rsvd_read_zero:
    assert property (r_q.st == ATR_IDLE && avs_read && lim_hit
        |=> avs_readdata[1:0] == 2'h0 && avs_readdata[31:16] == 16'h0000)
        else $error("reserved limit bits read nonzero");

    a_aux3_low_write:
    assert property (s_wr(`ATR_IDX_AUX3_LO)
        |=> r_q.lim[0] == $past(avs_writedata[15:2]))
        else $error("aux3 low limit not stored");

    a_aux3_high_write:
    assert property (s_wr(`ATR_IDX_AUX3_HI)
        |=> r_q.lim[1] == $past(avs_writedata[15:2]))
        else $error("aux3 high limit not stored");

    a_aux7_low_read:
    assert property (s_rd(`ATR_IDX_AUX7_LO)
        |=> avs_readdata == {16'h0000, $past(r_q.lim[8]), 2'h0})
        else $error("aux7 low limit readback wrong");

    a_aux7_high_write:
    assert property (s_wr(`ATR_IDX_AUX7_HI)
        |=> r_q.lim[9] == $past(avs_writedata[15:2]))
        else $error("aux7 high limit not stored");

    a_lot_id_read:
    assert property (s_rd(`ATR_IDX_LOT_HI) |=> avs_readdata == LOT_ID[63:32])
        else $error("lot identifier upper word wrong");

    a_serial_id_read:
    assert property (s_rd(`ATR_IDX_SERIAL) |=> avs_readdata == {16'h0000, SER_ID})
        else $error("serial identifier wrong");

    a_aux4_low_fault:
    assert property (sample_valid && sample_channel == 3'h4 &&
        sample_code[15:2] < r_q.lim[2] |=> aux_low_fault[1] && aux_fault_any)
        else $error("aux4 under-limit sample not flagged");

    a_aux3_high_sticky:
    assert property (aux_high_fault[0] && !flt_wr |=> aux_high_fault[0])
        else $error("aux3 high fault dropped without a clear");

    a_aux4_low_write:
    assert property (s_wr(`ATR_IDX_AUX4_LO)
        |=> r_q.lim[2] == $past(avs_writedata[15:2]))
        else $error("aux4 low limit not stored");

    a_aux4_high_write:
    assert property (s_wr(`ATR_IDX_AUX4_HI)
        |=> r_q.lim[3] == $past(avs_writedata[15:2]))
        else $error("aux4 high limit not stored");

    a_aux5_low_write:
    assert property (s_wr(`ATR_IDX_AUX5_LO)
        |=> r_q.lim[4] == $past(avs_writedata[15:2]))
        else $error("aux5 low limit not stored");

    a_aux5_high_write:
    assert property (s_wr(`ATR_IDX_AUX5_HI)
        |=> r_q.lim[5] == $past(avs_writedata[15:2]))
        else $error("aux5 high limit not stored");

    a_aux6_low_write:
    assert property (s_wr(`ATR_IDX_AUX6_LO)
        |=> r_q.lim[6] == $past(avs_writedata[15:2]))
        else $error("aux6 low limit not stored");

    a_aux6_high_write:
    assert property (s_wr(`ATR_IDX_AUX6_HI)
        |=> r_q.lim[7] == $past(avs_writedata[15:2]))
        else $error("aux6 high limit not stored");

    a_aux7_low_write:
    assert property (s_wr(`ATR_IDX_AUX7_LO)
        |=> r_q.lim[8] == $past(avs_writedata[15:2]))
        else $error("aux7 low limit not stored");

    a_lot_low_read:
    assert property (s_rd(`ATR_IDX_LOT_LO) |=> avs_readdata == LOT_ID[31:0])
        else $error("lot identifier lower word wrong");

    a_aux3_low_fault:
    assert property (sample_valid && sample_channel == 3'h3 &&
        sample_code[15:2] < r_q.lim[0] |=> aux_low_fault[0])
        else $error("aux3 under-limit sample not flagged");

    a_aux4_high_fault:
    assert property (sample_valid && sample_channel == 3'h4 &&
        sample_code[15:2] > r_q.lim[3] |=> aux_high_fault[1])
        else $error("aux4 over-limit sample not flagged");

    a_aux5_low_fault:
    assert property (sample_valid && sample_channel == 3'h5 &&
        sample_code[15:2] < r_q.lim[4] |=> aux_low_fault[2])
        else $error("aux5 under-limit sample not flagged");

    a_aux5_high_fault:
    assert property (sample_valid && sample_channel == 3'h5 &&
        sample_code[15:2] > r_q.lim[5] |=> aux_high_fault[2])
        else $error("aux5 over-limit sample not flagged");

    a_aux6_low_fault:
    assert property (sample_valid && sample_channel == 3'h6 &&
        sample_code[15:2] < r_q.lim[6] |=> aux_low_fault[3])
        else $error("aux6 under-limit sample not flagged");

    a_aux6_high_fault:
    assert property (sample_valid && sample_channel == 3'h6 &&
        sample_code[15:2] > r_q.lim[7] |=> aux_high_fault[3])
        else $error("aux6 over-limit sample not flagged");

    a_aux7_low_fault:
    assert property (sample_valid && sample_channel == 3'h7 &&
        sample_code[15:2] < r_q.lim[8] |=> aux_low_fault[4])
        else $error("aux7 under-limit sample not flagged");

    a_aux7_high_fault:
    assert property (sample_valid && sample_channel == 3'h7 &&
        sample_code[15:2] > r_q.lim[9] |=> aux_high_fault[4])
        else $error("aux7 over-limit sample not flagged");

    a_equal_no_fault:
    assert property (sample_valid && sample_channel == 3'h4 && !aux_low_fault[1] &&
        sample_code[15:2] == r_q.lim[2] |=> !aux_low_fault[1])
        else $error("sample equal to low limit flagged");

    a_fault_any_or:
    assert property (aux_fault_any == ((|aux_low_fault) || (|aux_high_fault)))
        else $error("summary fault flag disagrees with channel flags");

endmodule : atr_aux_limit_regs

// File: core/atr_regs.svh
`ifndef ATR_REGS_SVH
`define ATR_REGS_SVH

// register indices; byte address on the bus is index * 4
`define ATR_IDX_AUX3_LO   8'h9E
`define ATR_IDX_AUX3_HI   8'hA0
`define ATR_IDX_AUX4_LO   8'hA2
`define ATR_IDX_AUX4_HI   8'hA4
`define ATR_IDX_AUX5_LO   8'hA6
`define ATR_IDX_AUX5_HI   8'hA8
`define ATR_IDX_AUX6_LO   8'hAA
`define ATR_IDX_AUX6_HI   8'hAC
`define ATR_IDX_AUX7_LO   8'hAE
`define ATR_IDX_AUX7_HI   8'hB0
`define ATR_IDX_FAULT     8'hB8
`define ATR_IDX_LOT_HI    8'hBE
`define ATR_IDX_LOT_LO    8'hC2
`define ATR_IDX_SERIAL    8'hC6

// limit field position inside a 16-bit limit register
`define ATR_LIM_MSB       15
`define ATR_LIM_LSB       2
`define ATR_RSVD_ZERO     2'h0

// fault register field positions
`define ATR_FLT_LO_LSB    0
`define ATR_FLT_HI_LSB    8

// reset values: widest window, so no fault right after reset
`define ATR_LOW_RST       14'h0000
`define ATR_HIGH_RST      14'h3FFF
`define ATR_FLT_RST       5'h00
`define ATR_RDATA_RST     32'h0000_0000

// first auxiliary channel kept by this bank
`define ATR_FIRST_CH      3'h3

`endif

// File: core/atr_pkg.sv
package atr_pkg;

    // number of auxiliary channels held here (3 to 7)
    localparam int ATR_NCH   = 5;
    // one low and one high limit per channel
    localparam int ATR_NSLOT = 10;

    // 14-bit offset-binary limit code
    typedef logic [13:0] atr_lim_t;
    // all limits, slot 2c low and 2c+1 high of channel c
    typedef atr_lim_t [ATR_NSLOT-1:0] atr_lim_arr_t;
    // one flag per channel
    typedef logic [ATR_NCH-1:0] atr_flags_t;
    // sample channel number
    typedef logic [2:0] atr_chan_t;

    // bus handshake states, one-hot
    typedef enum logic [1:0] {
        ATR_IDLE = 2'b01,
        ATR_ACK  = 2'b10
    } atr_st_e;

    // whole state of the register bank
    typedef struct packed {
        atr_st_e      st;
        logic         wait_q;
        logic [31:0]  rdata;
        atr_lim_arr_t lim;
        atr_flags_t   lo_flt;
        atr_flags_t   hi_flt;
        logic         any_flt;
    } atr_state_s;

endpackage : atr_pkg

// File: core/atr_aux_cmp.sv
`timescale 1ns/1ps

module atr_aux_cmp (
    // sample and limits
    input  wire atr_pkg::atr_lim_t code,
    input  wire atr_pkg::atr_lim_t low_lim,
    input  wire atr_pkg::atr_lim_t high_lim,
    // compare results
    output logic                   below,
    output logic                   above
);
    import atr_pkg::*;

    // plain unsigned compare: offset-binary keeps 0 V at code zero
    // and 5 V at all ones, so order is monotonic
    always_comb begin
        below = (code < low_lim);
        above = (code > high_lim);
    end

endmodule : atr_aux_cmp

// File: tb/atr_adc_model.sv
`timescale 1ns/1ps

// sample source standing in for the converter; one sample per send
module atr_adc_model (
    // clock and reset
    input  wire logic               ref_clk,
    input  wire logic               sys_rst,
    // request from the bench
    input  wire logic               send,
    input  wire atr_pkg::atr_chan_t chan,
    input  wire logic [15:0]        code,
    // sample stream into the bank
    output logic                    sample_valid,
    output atr_pkg::atr_chan_t      sample_channel,
    output logic [15:0]             sample_code
);
    import atr_pkg::*;
    // idle cycles show inverted junk so a stale code is never compared by luck
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sample_valid   <= 1'b0;
            sample_channel <= 3'h0;
            sample_code    <= 16'h0000;
        end else begin
            sample_valid   <= send;
            sample_channel <= send ? chan : ~sample_channel;
            sample_code    <= send ? code : ~sample_code;
        end
    end
endmodule : atr_adc_model

// File: tb/tb_aux_threshold_and_id_regs.sv
`timescale 1ns/1ps
`include "atr_regs.svh"

module tb_aux_threshold_and_id_regs;
    import atr_pkg::*;
    localparam logic [63:0] LOT = 64'h5A5A_1234_C3C3_8765; // arbitrary value
    localparam logic [15:0] SER = 16'h6E21;                // arbitrary value
    logic        ref_clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, send = 0;
    logic [9:0]  avs_address = '0;
    logic [3:0]  avs_byteenable = '0;
    logic [31:0] avs_writedata = '0, avs_readdata, wd;
    logic        avs_waitrequest, sample_valid, aux_fault_any;
    atr_chan_t   chan = '0, sample_channel;
    logic [15:0] code = '0, sample_code;
    atr_flags_t  aux_low_fault, aux_high_fault;
    logic [31:0] exp_q[$];  // expected read data, oldest first
    int          err_count = 0, comparisons = 0, cyc = 0;

    always #4 ref_clk = ~ref_clk;

    atr_adc_model i_adc (.ref_clk(ref_clk), .sys_rst(sys_rst), .send(send), .chan(chan), .code(code),
        .sample_valid(sample_valid), .sample_channel(sample_channel), .sample_code(sample_code));
    atr_aux_limit_regs #(.LOT_ID(LOT), .SER_ID(SER)) i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sample_valid(sample_valid), .sample_channel(sample_channel),
        .sample_code(sample_code), .aux_low_fault(aux_low_fault), .aux_high_fault(aux_high_fault),
        .aux_fault_any(aux_fault_any));

    // single comparison point
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic final_report;
        $display("checks %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report

    // one avalon access; an idle cycle first keeps each signal to one drive per step
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d, input logic [3:0] be);
        @(posedge ref_clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= {idx, 2'b00};
        avs_writedata <= d;
        avs_byteenable <= be;
        // wait for the answer edge; only the bench timeout ends a hung wait
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    // read with the expected word noted first
    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        exp_q.push_back(exp);
        bus(1'b0, idx, 32'h0, 4'h0);
    endtask : rd

    task automatic smp(input atr_chan_t c, input logic [15:0] v);
        @(posedge ref_clk);
        send <= 1'b1;
        chan <= c;
        code <= v;
        @(posedge ref_clk);
        send <= 1'b0;
    endtask : smp

    // monitor: read data counts only at the answer edge
    always @(posedge ref_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            if (exp_q.size() == 0) chk("unexpected read", 32'h1, 32'h0);
            else chk("readdata", avs_readdata, exp_q.pop_front());
        end
    end

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            final_report();
        end
    end

    initial begin
        void'($urandom(38969));
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        // limits after reset: widest window
        for (int i = 0; i < 10; i++) rd(8'h9E + 8'(2 * i), i[0] ? 32'h0000_FFFC : 32'h0);
        $display("test reset values done");
        // random limits, upper half set, reserved bits written as zero
        for (int i = 0; i < 10; i++) begin
            wd = ($urandom() | 32'hFFFF_0000) & 32'hFFFF_FFFC;
            bus(1'b1, 8'h9E + 8'(2 * i), wd, 4'hF);
            rd(8'h9E + 8'(2 * i), {16'h0, wd[15:2], 2'b00});
        end
        $display("test limit storage done");
        // identifiers are read-only; unmapped index reads zero
        bus(1'b1, `ATR_IDX_LOT_HI, 32'hFFFF_FFFF, 4'hF);
        rd(`ATR_IDX_LOT_HI, LOT[63:32]);
        rd(`ATR_IDX_LOT_LO, LOT[31:0]);
        rd(`ATR_IDX_SERIAL, {16'h0, SER});
        rd(8'hFF, 32'h0);
        $display("test identifiers done");
        // window 0x1000..0x3000 on every channel
        for (int c = 0; c < 5; c++) begin
            bus(1'b1, 8'h9E + 8'(4 * c), 32'h0000_4000, 4'h3);
            bus(1'b1, 8'hA0 + 8'(4 * c), 32'h0000_C000, 4'h3);
        end
        for (int c = 3; c < 8; c++) begin
            smp(atr_chan_t'(c), 16'h4000);
            smp(atr_chan_t'(c), 16'hC003);
            smp(atr_chan_t'(c), c[0] ? 16'h3FFC : 16'hC004);
        end
        smp(3'h2, 16'h0000);
        rd(`ATR_IDX_FAULT, 32'h0000_0A15);
        chk("low_fault", {27'h0, aux_low_fault}, 32'h15);
        chk("high_fault", {27'h0, aux_high_fault}, 32'h0A);
        chk("fault_any", {31'h0, aux_fault_any}, 32'h1);
        bus(1'b1, `ATR_IDX_FAULT, 32'h0000_001F, 4'h1);
        rd(`ATR_IDX_FAULT, 32'h0000_0A00);
        bus(1'b1, `ATR_IDX_FAULT, 32'h0000_1F00, 4'h2);
        @(posedge ref_clk);
        chk("fault_any", {31'h0, aux_fault_any}, 32'h0);
        // other side of every window, so each channel raises its other flag
        for (int c = 3; c < 8; c++) smp(atr_chan_t'(c), c[0] ? 16'hC004 : 16'h3FFC);
        rd(`ATR_IDX_FAULT, 32'h0000_150A);
        chk("high_fault", {27'h0, aux_high_fault}, 32'h15);
        $display("test fault flags done");
        repeat (3) @(posedge ref_clk);
        chk("pending reads", exp_q.size(), 32'h0);
        final_report();
    end
endmodule : tb_aux_threshold_and_id_regs
